// ==== acp_pkg.sv ====
package acp_pkg;
	// timing
	localparam int T_CLK_NS     = 10;
	localparam int T_BSY_MAX_NS = 400;
	localparam int BSY_MAX_CYC  = T_BSY_MAX_NS / T_CLK_NS;
	localparam int T_DRQ_MAX_NS = 700;
	localparam int DRQ_MAX_CYC  = T_DRQ_MAX_NS / T_CLK_NS;
	// task file register select
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_ERR  = 3'h1;
	localparam logic [2:0] A_SC   = 3'h2;
	localparam logic [2:0] A_SN   = 3'h3;
	localparam logic [2:0] A_CL   = 3'h4;
	localparam logic [2:0] A_CH   = 3'h5;
	localparam logic [2:0] A_DH   = 3'h6;
	localparam logic [2:0] A_CMD  = 3'h7;
	localparam int TF_REGS = 8;
	// status and error bits
	localparam int ST_BSY  = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DF   = 5;
	localparam int ST_DRQ  = 3;
	localparam int ST_ERR  = 0;
	localparam int ER_ABRT = 2;
	localparam logic [7:0] ST_RESET = 8'h50;
	localparam logic [7:0] ER_NONE  = 8'h00;
	localparam logic [7:0] TF_RESET = 8'h00;
	localparam logic [7:0] DH_USED_MASK = 8'hB0;
	localparam logic [7:0] DH_DEFAULT   = 8'hA0;
	// command codes
	localparam logic [7:0] CMD_CHK_PM     = 8'hE5;
	localparam logic [7:0] CMD_CHK_PM_OLD = 8'h98;
	localparam logic [7:0] CMD_STBY_IMM   = 8'hE0;
	localparam logic [7:0] CMD_STBY_IMM_O = 8'h94;
	localparam logic [7:0] CMD_IDLE_IMM   = 8'hE1;
	localparam logic [7:0] CMD_IDLE_IMM_O = 8'h95;
	localparam logic [7:0] CMD_STBY       = 8'hE2;
	localparam logic [7:0] CMD_STBY_O     = 8'h96;
	localparam logic [7:0] CMD_IDLE       = 8'hE3;
	localparam logic [7:0] CMD_IDLE_O     = 8'h97;
	localparam logic [7:0] CMD_SLEEP      = 8'hE6;
	localparam logic [7:0] CMD_SLEEP_O    = 8'h99;
	// power mode answers in sector count
	localparam logic [7:0] SC_STANDBY = 8'h00;
	localparam logic [7:0] SC_IDLE    = 8'h80;
	localparam logic [7:0] SC_ACTIVE  = 8'hFF;
	typedef enum logic [1:0] {PM_STANDBY = 2'h0, PM_IDLE = 2'h1, PM_ACTIVE = 2'h2} acp_pm_t;
	// host read phases
	localparam logic [1:0] PH_EMIT = 2'h0;
	localparam logic [1:0] PH_WAIT = 2'h1;
	localparam logic [1:0] PH_CAP  = 2'h2;
	// host apb map
	localparam int APB_AW = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_INT  = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0C;
	localparam logic [7:0] OFF_DH   = 8'h10;
	localparam int CTRL_GO = 8;
	localparam int INT_DONE = 0;
	localparam int INT_ERR  = 1;
	localparam int INT_W    = 2;
endpackage

// ==== acp_if.sv ====
`timescale 1ns/100ps
interface acp_if;
	logic [2:0] addr;
	logic       wr_stb;
	logic       rd_stb;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       intrq;
	modport dev (input addr, input wr_stb, input rd_stb, input wdata, output rdata, output intrq);
	modport host (output addr, output wr_stb, output rd_stb, output wdata, input rdata, input intrq);
endinterface

// ==== acp_device.sv ====
`timescale 1ns/100ps
// Operation
// - save attributes on idle, standby immediate, sleep (code saves on idle immediate E1h/95h, not on idle E3h/97h)
// - save attributes before timer drops to standby
// - host loads parameters before command code
// - busy set within 400 ns of command
// - drq-with-busy-clear within 700 ns for data-out
// - host prefers new power command codes
// - host writes unused bits as zero
// - status valid at end, error valid on err
// - error outputs returned on unrecoverable error
// - 98h and E5h both query power mode
// - standby: busy, count 00h, unbusy, interrupt
// - idle: busy, count 80h, unbusy, interrupt
// - active: busy, count FFh, unbusy, interrupt
// - no power management: abort, abrt and err
// - host queries only while drdy is set
// - drdy, df, err, abrt valid on error
module acp_device #(
	parameter int EXEC_CYC = 4
)(
	// clock, reset, enable
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	// task file side
	acp_if.dev                    bus,
	// drive state
	input  wire logic             pm_supported,
	input  wire logic             smart_en,
	input  wire acp_pkg::acp_pm_t pm_mode,
	input  wire logic             standby_timer_exp,
	// drive events
	output logic                  attr_save,
	output logic                  standby_go,
	output logic                  pm_cmd_valid,
	output logic [7:0]            pm_cmd_code,
	output logic                  busy
);
	import acp_pkg::*;

	localparam int CW = (EXEC_CYC > 1) ? $clog2(EXEC_CYC) : 1;
	localparam logic [CW-1:0] EXEC_LAST = CW'(EXEC_CYC - 1);
	localparam logic [CW-1:0] CNT_ZERO  = '0;

	typedef enum logic [3:0]
	{
		S_IDLE = 4'b0001,
		S_EXEC = 4'b0010,
		S_LOAD = 4'b0100,
		S_DONE = 4'b1000
	} acp_dst_t;

	acp_dst_t        state_r;
	acp_dst_t        state_nxt;
	logic [7:0]      tf_r [TF_REGS];
	logic [7:0]      tf_nxt [TF_REGS];
	logic [7:0]      stat_r;
	logic [7:0]      stat_nxt;
	logic [7:0]      err_r;
	logic [7:0]      err_nxt;
	logic [7:0]      cmd_r;
	logic [7:0]      rdata_r;
	logic [CW-1:0]   cnt_r;
	logic [CW-1:0]   cnt_nxt;
	logic            intrq_r;
	logic            attr_save_r;
	logic            timer_hit_r;
	logic            standby_go_r;
	logic            pmv_r;
	logic [7:0]      pmc_r;

	function automatic logic save_code(input logic [7:0] c);
		return c inside {CMD_STBY_IMM, CMD_STBY_IMM_O, CMD_IDLE_IMM, CMD_IDLE_IMM_O, CMD_SLEEP, CMD_SLEEP_O};
	endfunction

	function automatic logic chk_code(input logic [7:0] c);
		return (c == CMD_CHK_PM) || (c == CMD_CHK_PM_OLD);
	endfunction

	function automatic logic other_pm(input logic [7:0] c);
		return save_code(c) || (c inside {CMD_STBY, CMD_STBY_O, CMD_IDLE, CMD_IDLE_O});
	endfunction

	// decode
	wire logic bsy       = stat_r[ST_BSY];
	wire logic wr_cmd    = ce & bus.wr_stb & (bus.addr == A_CMD) & ~bsy;
	// writes into the task file while busy are dropped so a result is never overwritten
	wire logic wr_tf     = ce & bus.wr_stb & (bus.addr != A_CMD) & ~bsy;
	wire logic rd_stat   = ce & bus.rd_stb & (bus.addr == A_CMD);
	wire logic is_chk    = chk_code(cmd_r);
	wire logic is_pm     = is_chk | other_pm(cmd_r);
	// commands outside the power set are not handled here and end aborted
	wire logic abort     = ~is_pm | ~pm_supported;
	wire logic [7:0] pm_sc = (pm_mode == PM_STANDBY) ? SC_STANDBY :
	                         (pm_mode == PM_IDLE)    ? SC_IDLE    : SC_ACTIVE;
	wire logic load_sc   = ce & (state_r == S_LOAD) & is_chk & ~abort;
	wire logic timer_hit = ce & standby_timer_exp & (pm_mode == PM_IDLE) & smart_en;
	wire logic save_now  = wr_cmd & smart_en & save_code(bus.wdata);
	wire logic intrq_set = ce & (state_r == S_DONE);
	wire logic [7:0] rd_val = (bus.addr == A_CMD) ? stat_r :
	                          (bus.addr == A_ERR) ? err_r  : tf_r[bus.addr];

	// command sequencer
	always_comb
	begin
		state_nxt = state_r;
		stat_nxt  = stat_r;
		err_nxt   = err_r;
		cnt_nxt   = cnt_r;
		if (ce)
		begin
			case (state_r)
				S_IDLE:
					if (wr_cmd)
					begin
						stat_nxt[ST_BSY] = 1'b1;
						stat_nxt[ST_DRQ] = 1'b0;
						stat_nxt[ST_ERR] = 1'b0;
						cnt_nxt          = EXEC_LAST;
						state_nxt        = S_EXEC;
					end
				S_EXEC:
					if (cnt_r == CNT_ZERO)
						state_nxt = S_LOAD;
					else
						cnt_nxt = cnt_r - 1'b1;
				S_LOAD:
				begin
					if (abort)
					begin
						err_nxt          = ER_NONE;
						err_nxt[ER_ABRT] = 1'b1;
						stat_nxt[ST_ERR] = 1'b1;
					end
					else
						err_nxt = ER_NONE;
					state_nxt = S_DONE;
				end
				S_DONE:
				begin
					stat_nxt[ST_BSY]  = 1'b0;
					stat_nxt[ST_DRDY] = 1'b1;
					stat_nxt[ST_DF]   = 1'b0;
					state_nxt         = S_IDLE;
				end
				default:
					state_nxt = S_IDLE;
			endcase
		end
	end

	// task file registers; the count slot also takes the power mode answer
	genvar g;
	generate
		for (g = 0; g < TF_REGS; g++)
		begin : g_tf
			assign tf_nxt[g] = ((3'(g) == A_SC) && load_sc) ? pm_sc :
			                   (wr_tf && (bus.addr == 3'(g))) ? bus.wdata : tf_r[g];
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					tf_r[g] <= TF_RESET;
				else
					tf_r[g] <= tf_nxt[g];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			stat_r  <= ST_RESET;
			err_r   <= ER_NONE;
			cnt_r   <= CNT_ZERO;
		end
		else
		begin
			state_r <= state_nxt;
			stat_r  <= stat_nxt;
			err_r   <= err_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_r   <= TF_RESET;
			rdata_r <= TF_RESET;
			intrq_r <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_cmd)
				cmd_r <= bus.wdata;
			if (bus.rd_stb)
				rdata_r <= rd_val;
			// raising wins over a status read landing in the same cycle
			intrq_r <= intrq_set | (intrq_r & ~rd_stat & ~wr_cmd);
		end
	end

	// attribute save ahead of the standby drop: save pulses one cycle before standby_go
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			attr_save_r  <= 1'b0;
			timer_hit_r  <= 1'b0;
			standby_go_r <= 1'b0;
			pmv_r        <= 1'b0;
			pmc_r        <= TF_RESET;
		end
		else if (ce)
		begin
			attr_save_r  <= save_now | timer_hit;
			timer_hit_r  <= timer_hit;
			standby_go_r <= timer_hit_r;
			pmv_r        <= wr_cmd & pm_supported & other_pm(bus.wdata);
			if (wr_cmd)
				pmc_r <= bus.wdata;
		end
	end

	assign bus.rdata    = rdata_r;
	assign bus.intrq    = intrq_r;
	assign attr_save    = attr_save_r;
	assign standby_go   = standby_go_r;
	assign pm_cmd_valid = pmv_r;
	assign pm_cmd_code  = pmc_r;
	assign busy         = bsy;
endmodule

// ==== acp_host.sv ====
`timescale 1ns/100ps
module acp_host (
	// clock, reset, enable
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [acp_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic                           irq,
	// task file side
	acp_if.host                            bus
);
	import acp_pkg::*;

	typedef enum logic [7:0]
	{
		H_IDLE = 8'b00000001,
		H_POLL = 8'b00000010,
		H_DH   = 8'b00000100,
		H_CMD  = 8'b00001000,
		H_WAIT = 8'b00010000,
		H_STAT = 8'b00100000,
		H_ERR  = 8'b01000000,
		H_SC   = 8'b10000000
	} acp_hst_t;

	acp_hst_t          hs_r;
	acp_hst_t          hs_nxt;
	logic [1:0]        ph_r;
	logic [1:0]        ph_nxt;
	logic [2:0]        a_r;
	logic [2:0]        a_nxt;
	logic              wr_r;
	logic              wr_nxt;
	logic              rd_r;
	logic              rd_nxt;
	logic [7:0]        wd_r;
	logic [7:0]        wd_nxt;
	logic [7:0]        hstat_r;
	logic [7:0]        herr_r;
	logic [7:0]        hsc_r;
	logic [7:0]        code_r;
	logic [7:0]        dh_r;
	logic [INT_W-1:0]  int_r;
	logic [INT_W-1:0]  mask_r;
	logic [31:0]       prdata_r;

	// apb decode
	wire logic apb_acc  = psel & penable & ce;
	wire logic wr_acc   = apb_acc & pwrite;
	wire logic rd_acc   = apb_acc & ~pwrite;
	wire logic sel_ctrl = paddr == OFF_CTRL;
	wire logic sel_stat = paddr == OFF_STAT;
	wire logic sel_int  = paddr == OFF_INT;
	wire logic sel_mask = paddr == OFF_MASK;
	wire logic sel_dh   = paddr == OFF_DH;
	wire logic mapped   = sel_ctrl | sel_stat | sel_int | sel_mask | sel_dh;
	wire logic h_idle   = hs_r == H_IDLE;
	wire logic go       = wr_acc & sel_ctrl & pwdata[CTRL_GO] & h_idle;
	wire logic is_rd    = (hs_r == H_POLL) | (hs_r == H_STAT) | (hs_r == H_ERR) | (hs_r == H_SC);
	wire logic cap      = ce & is_rd & (ph_r == PH_CAP);
	wire logic [2:0] rd_addr = (hs_r == H_ERR) ? A_ERR : (hs_r == H_SC) ? A_SC : A_CMD;
	wire logic ev_done  = cap & (hs_r == H_SC);
	wire logic [INT_W-1:0] ev = {ev_done & hstat_r[ST_ERR], ev_done};
	wire logic [31:0] rd_val = sel_ctrl ? {24'h000000, code_r} :
	                           sel_stat ? {7'h00, ~h_idle, hsc_r, herr_r, hstat_r} :
	                           sel_int  ? {{(32 - INT_W){1'b0}}, int_r} :
	                           sel_mask ? {{(32 - INT_W){1'b0}}, mask_r} :
	                           sel_dh   ? {24'h000000, dh_r} : 32'h00000000;

	// bus sequencer; drives are registered and reach the device one cycle later
	always_comb
	begin
		hs_nxt = hs_r;
		ph_nxt = ph_r;
		a_nxt  = a_r;
		wd_nxt = wd_r;
		wr_nxt = 1'b0;
		rd_nxt = 1'b0;
		case (hs_r)
			H_IDLE:
				if (go)
				begin
					hs_nxt = H_POLL;
					ph_nxt = PH_EMIT;
				end
			H_POLL, H_STAT, H_ERR, H_SC:
				case (ph_r)
					PH_EMIT:
					begin
						a_nxt  = rd_addr;
						rd_nxt = 1'b1;
						ph_nxt = PH_WAIT;
					end
					PH_WAIT:
						ph_nxt = PH_CAP;
					default:
					begin
						ph_nxt = PH_EMIT;
						if (hs_r == H_POLL)
							hs_nxt = (bus.rdata[ST_DRDY] & ~bus.rdata[ST_BSY]) ? H_DH : H_POLL;
						else if (hs_r == H_STAT)
							hs_nxt = bus.rdata[ST_ERR] ? H_ERR : H_SC;
						else if (hs_r == H_ERR)
							hs_nxt = H_SC;
						else
							hs_nxt = H_IDLE;
					end
				endcase
			H_DH:
			begin
				a_nxt  = A_DH;
				wd_nxt = dh_r & DH_USED_MASK;
				wr_nxt = 1'b1;
				hs_nxt = H_CMD;
			end
			H_CMD:
			begin
				a_nxt  = A_CMD;
				wd_nxt = code_r;
				wr_nxt = 1'b1;
				hs_nxt = H_WAIT;
			end
			H_WAIT:
				if (bus.intrq)
					hs_nxt = H_STAT;
			default:
				hs_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hs_r <= H_IDLE;
			ph_r <= PH_EMIT;
			a_r  <= A_CMD;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			wd_r <= TF_RESET;
		end
		else if (ce)
		begin
			hs_r <= hs_nxt;
			ph_r <= ph_nxt;
			a_r  <= a_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			wd_r <= wd_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hstat_r <= TF_RESET;
			herr_r  <= ER_NONE;
			hsc_r   <= TF_RESET;
		end
		else if (go)
			herr_r <= ER_NONE;
		else if (cap && hs_r == H_STAT)
			hstat_r <= bus.rdata;
		else if (cap && hs_r == H_ERR)
			herr_r <= bus.rdata;
		else if (cap && hs_r == H_SC)
			hsc_r <= bus.rdata;
	end

	// software registers; an event in the read-clear cycle survives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code_r   <= CMD_CHK_PM;
			dh_r     <= DH_DEFAULT;
			mask_r   <= '0;
			int_r    <= '0;
			prdata_r <= 32'h00000000;
		end
		else if (ce)
		begin
			if (wr_acc && sel_ctrl && h_idle)
				code_r <= pwdata[7:0];
			if (wr_acc && sel_dh)
				dh_r <= pwdata[7:0];
			if (wr_acc && sel_mask)
				mask_r <= pwdata[INT_W-1:0];
			int_r <= (int_r & ~{INT_W{rd_acc & sel_int}}) | ev;
			if (psel && !penable)
				prdata_r <= rd_val;
		end
	end

	assign prdata     = prdata_r;
	assign pready     = ce;
	assign pslverr    = apb_acc & ~mapped;
	assign irq        = |(int_r & mask_r);
	assign bus.addr   = a_r;
	assign bus.wr_stb = wr_r;
	assign bus.rd_stb = rd_r;
	assign bus.wdata  = wd_r;
endmodule

// ==== acp_asserts.sv ====
`timescale 1ns/100ps
module acp_asserts
	import acp_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       ce,
	// task file
	input wire logic [2:0] addr,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       intrq,
	// device status
	input wire logic       busy
);
	wire logic cmd_wr = wr_stb && (addr == A_CMD);
	wire logic st_rd  = rd_stb && (addr == A_CMD);
	wire logic dh_wr  = wr_stb && (addr == A_DH);
	logic       st_rd_r;
	logic [7:0] last_st_r;
	// last status the host saw, so a command can be tied to a ready poll
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_rd_r   <= 1'b0;
			last_st_r <= 8'h00;
		end
		else
		begin
			st_rd_r <= st_rd;
			if (st_rd_r)
				last_st_r <= rdata;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	// a frozen clock enable stretches every timed window, so attempts spanning it are dropped
	default disable iff (!presetn || !ce);
	property p_busy_seq;
		cmd_wr |=> busy [*6] ##1 !busy;
	endproperty
	a_busy_seq: assert property (p_busy_seq) else $error("busy window wrong");
	property p_intrq_seq;
		cmd_wr |=> !intrq [*6] ##1 intrq;
	endproperty
	a_intrq_seq: assert property (p_intrq_seq) else $error("intrq timing wrong");
	property p_busy_intrq;
		$fell(busy) |-> intrq;
	endproperty
	a_busy_intrq: assert property (p_busy_intrq) else $error("busy cleared without intrq");
	property p_intrq_clr;
		st_rd && intrq |=> !intrq;
	endproperty
	a_intrq_clr: assert property (p_intrq_clr) else $error("intrq not cleared by status read");
	property p_intrq_hold;
		intrq && !st_rd && !cmd_wr |=> intrq;
	endproperty
	a_intrq_hold: assert property (p_intrq_hold) else $error("intrq dropped early");
	property p_done_stat;
		st_rd && intrq |=> !rdata[ST_BSY] && rdata[ST_DRDY] && !rdata[ST_DF];
	endproperty
	a_done_stat: assert property (p_done_stat) else $error("final status not valid");
	property p_rdata_stable;
		!rd_stb |=> $stable(rdata);
	endproperty
	a_rdata_stable: assert property (p_rdata_stable) else $error("read data moved");
	property p_rd_pulse;
		rd_stb |=> !rd_stb ##1 !rd_stb;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe spacing wrong");
	property p_dh_zero;
		dh_wr |-> (wdata & ~DH_USED_MASK) == 8'h00;
	endproperty
	a_dh_zero: assert property (p_dh_zero) else $error("unused head bits set");
	property p_cmd_ready;
		cmd_wr |-> last_st_r[ST_DRDY] && !last_st_r[ST_BSY];
	endproperty
	a_cmd_ready: assert property (p_cmd_ready) else $error("command issued while not ready");
endmodule

// ==== ata_command_intake_power_mode_query_tb.sv ====
`timescale 1ns/100ps
module ata_command_intake_power_mode_query_tb;
	import acp_pkg::*;
	typedef struct {logic sup; acp_pm_t mode; logic [7:0] code; logic [7:0] sc; logic err; logic save; logic pmv;} acp_row_t;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [7:0]  paddr, pm_cmd_code, last_code;
	logic [31:0] pwdata, prdata, r;
	logic        pm_supported, smart_en, standby_timer_exp, attr_save, standby_go, pm_cmd_valid, busy;
	acp_pm_t     pm_mode;
	int          bad_count = 0, tests_run = 0, save_n = 0, go_n = 0, pmv_n = 0;
	time         t_save, t_go;
	// abort rows follow the active query so an untouched count is visible
	acp_row_t rows [14] = '{
		'{1'b1, PM_ACTIVE, 8'hE5, 8'hFF, 1'b0, 1'b0, 1'b0},
		'{1'b0, PM_ACTIVE, 8'hE5, 8'hFF, 1'b1, 1'b0, 1'b0},
		'{1'b1, PM_ACTIVE, 8'h50, 8'hFF, 1'b1, 1'b0, 1'b0},
		'{1'b1, PM_IDLE, 8'h98, 8'h80, 1'b0, 1'b0, 1'b0},
		'{1'b1, PM_STANDBY, 8'hE5, 8'h00, 1'b0, 1'b0, 1'b0},
		'{1'b1, PM_ACTIVE, 8'hE1, 8'h00, 1'b0, 1'b1, 1'b1},
		'{1'b1, PM_STANDBY, 8'hE6, 8'h00, 1'b0, 1'b1, 1'b1},
		'{1'b1, PM_IDLE, 8'h94, 8'h00, 1'b0, 1'b1, 1'b1},
		'{1'b1, PM_IDLE, 8'hE3, 8'h00, 1'b0, 1'b0, 1'b1},
		'{1'b1, PM_ACTIVE, 8'hE2, 8'h00, 1'b0, 1'b0, 1'b1},
		'{1'b1, PM_ACTIVE, 8'h97, 8'h00, 1'b0, 1'b0, 1'b1},
		'{1'b1, PM_ACTIVE, 8'h95, 8'h00, 1'b0, 1'b1, 1'b1},
		'{1'b1, PM_IDLE, 8'h96, 8'h00, 1'b0, 1'b0, 1'b1},
		'{1'b1, PM_ACTIVE, 8'h99, 8'h00, 1'b0, 1'b1, 1'b1}};

	acp_if acp_if_i ();
	acp_device #(.EXEC_CYC(4)) acp_device_i (.pclk(pclk), .presetn(presetn), .ce(ce), .bus(acp_if_i.dev),
		.pm_supported(pm_supported), .smart_en(smart_en), .pm_mode(pm_mode), .standby_timer_exp(standby_timer_exp),
		.attr_save(attr_save), .standby_go(standby_go), .pm_cmd_valid(pm_cmd_valid), .pm_cmd_code(pm_cmd_code),
		.busy(busy));
	acp_host acp_host_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .bus(acp_if_i.host));
	acp_asserts acp_asserts_i (.pclk(pclk), .presetn(presetn), .ce(ce), .addr(acp_if_i.addr),
		.wr_stb(acp_if_i.wr_stb), .rd_stb(acp_if_i.rd_stb), .wdata(acp_if_i.wdata), .rdata(acp_if_i.rdata),
		.intrq(acp_if_i.intrq), .busy(busy));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		if (attr_save === 1'b1)
		begin
			save_n++;
			t_save = $time;
		end
		if (standby_go === 1'b1)
		begin
			go_n++;
			t_go = $time;
		end
		if (pm_cmd_valid === 1'b1)
		begin
			pmv_n++;
			last_code = pm_cmd_code;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task finish_test;
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// entered just after a rising edge; leaves one idle cycle so strobes never double-assign
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		chk(n < 400, 1);
	endtask

	task run(input acp_row_t w);
		int s0, p0;
		pm_supported <= w.sup;
		pm_mode <= w.mode;
		s0 = save_n;
		p0 = pmv_n;
		apb(1'b1, OFF_CTRL, {23'h0, 1'b1, w.code});
		wait_irq();
		apb(1'b0, OFF_INT, 32'h0);
		chk(r[INT_ERR], w.err);
		if (!w.err)
			chk(r[INT_DONE], 1);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(r[24:16], {1'b0, w.sc});
		chk(r[15:8] & 8'h04, {5'h0, w.err, 2'h0});
		chk(r[7:0] & 8'hE9, {7'h20, w.err});
		chk(save_n - s0, w.save);
		chk(pmv_n - p0, w.pmv);
		if (w.pmv)
			chk(last_code, w.code);
	endtask

	initial
	begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pm_supported = 1'b1;
		smart_en = 1'b1;
		standby_timer_exp = 1'b0;
		pm_mode = PM_ACTIVE;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r[7:0], CMD_CHK_PM);
		apb(1'b0, OFF_DH, 32'h0);
		chk(r[7:0], DH_DEFAULT);
		apb(1'b0, OFF_MASK, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk(e, 1);
		chk(r, 32'h0);
		apb(1'b1, 8'h14, 32'h1);
		chk(e, 1);
		// masked: event is recorded but irq stays low
		apb(1'b1, OFF_CTRL, 32'h1E5);
		repeat (40) @(posedge pclk);
		chk(irq, 0);
		apb(1'b0, OFF_INT, 32'h0);
		chk(r[INT_DONE], 1);
		apb(1'b0, OFF_INT, 32'h0);
		chk(r, 32'h0);
		apb(1'b1, OFF_MASK, 32'h3);
		apb(1'b0, OFF_MASK, 32'h0);
		chk(r, 32'h3);
		foreach (rows[i])
			run(rows[i]);
		// second order while the first runs must be dropped
		apb(1'b1, OFF_CTRL, 32'h1E5);
		apb(1'b1, OFF_CTRL, 32'h1E0);
		wait_irq();
		apb(1'b0, OFF_INT, 32'h0);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r[7:0], 8'hE5);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(r[23:16], SC_ACTIVE);
		pm_mode <= PM_IDLE;
		standby_timer_exp <= 1'b1;
		@(posedge pclk);
		standby_timer_exp <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(go_n, 1);
		chk(32'(t_go - t_save), 10);
		smart_en <= 1'b0;
		// the count still holds the active answer of the dropped-order query
		run('{1'b1, PM_IDLE, 8'hE0, 8'hFF, 1'b0, 1'b0, 1'b1});
		apb(1'b1, OFF_DH, 32'h4F);
		apb(1'b0, OFF_DH, 32'h0);
		chk(r[7:0], 8'h4F);
		// clock enable low freezes the device in mid-command
		apb(1'b1, OFF_CTRL, 32'h1E5);
		while (busy !== 1'b1)
			@(posedge pclk);
		ce <= 1'b0;
		repeat (20) @(posedge pclk);
		chk(busy, 1);
		chk(irq, 0);
		ce <= 1'b1;
		wait_irq();
		apb(1'b0, OFF_INT, 32'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(r[23:16], SC_IDLE);
		run('{1'b1, PM_STANDBY, 8'hE5, 8'h00, 1'b0, 1'b0, 1'b0});
		finish_test();
	end

	initial
	begin
		#400000;
		bad_count++;
		finish_test();
	end
endmodule
